/* File: src/cfg_device_end.sv */
// Purpose: device end that decodes configuration messages and replies on the link
// Assumes: the destination stands with the opening token of each message
// Notes: registers are flip-flop banks; their contents leave on o_tile_cfg, o_node_cfg and o_ps_cfg
`timescale 1ns/10ps
`default_nettype none
module cfg_device_end #(
	parameter int TILE_REGS = 8,
	parameter int NODE_REGS = 8,
	parameter int PS_REGS = 16,
	parameter logic [15:0] TILE_ID = 16'h0000,
	parameter logic [15:0] NODE_ID = 16'h0000
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// link
	cfg_msg_if.device link,
	// register contents toward the rest of the chip
	output logic [TILE_REGS-1:0][31:0] o_tile_cfg,
	output logic [NODE_REGS-1:0][31:0] o_node_cfg,
	output logic [PS_REGS-1:0][31:0] o_ps_cfg
);
	import cfg_msg_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_BODY = 5'b00010,
		S_DRAIN = 5'b00100,
		S_EXEC = 5'b01000,
		S_REPLY = 5'b10000
	} dstate_type;

	typedef struct packed {
		dstate_type st;
		logic write;
		logic node;
		logic for_us;
		logic fail;
		logic [3:0] cnt;
		logic [23:0] rid;
		logic [15:0] regnum;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [2:0] idx;
		logic [2:0] len;
		logic req_ready;
		logic rsp_valid;
		tok_type rsp_tok;
		logic ps_ack;
		logic ps_ok;
		logic [31:0] ps_rdata;
		logic [TILE_REGS-1:0][31:0] tile;
		logic [NODE_REGS-1:0][31:0] node_bank;
		logic [PS_REGS-1:0][31:0] ps;
	} dev_type;

	dev_type d_reg, d_next;

	// register number inside a bank of n words
	function automatic logic reg_ok(input logic [15:0] r, input int n);
		return 32'(r) < n;
	endfunction : reg_ok

	// token idx of the reply being sent
	function automatic tok_type reply_tok(input dev_type d, input logic [2:0] i);
		tok_type t;
		t = '{ctrl: 1'b1, val: TOK_END};
		if (i == 3'h0) begin
			t.val = d.fail ? TOK_NACK : TOK_ACK;
		end else if (i != d.len - 3'h1) begin
			t = '{ctrl: 1'b0, val: byte_msb(d.rdata, 2'(i - 3'h1))};
		end
		return t;
	endfunction : reply_tok

	always_comb begin
		logic take;
		logic [3:0] body;
		take = link.req_valid && d_reg.req_ready;
		body = d_reg.write ? WR_BODY : RD_BODY;
		d_next = d_reg;
		d_next.ps_ack = 1'b0;

		// processor-status access answers one cycle after the request
		if (link.ps_req) begin
			d_next.ps_ack = 1'b1;
			d_next.ps_ok = 1'b0;
			d_next.ps_rdata = 32'h0;
			if (link.ps_rid[7:0] == PS_TYPE
				&& reg_ok({8'h00, link.ps_rid[15:PS_SHIFT]}, PS_REGS)) begin
				d_next.ps_ok = 1'b1;
				if (link.ps_wr) begin
					d_next.ps[link.ps_rid[15:PS_SHIFT]] = link.ps_wdata;
				end else begin
					d_next.ps_rdata = d_reg.ps[link.ps_rid[15:PS_SHIFT]];
				end
			end
		end

		case (d_reg.st)
			S_IDLE: begin
				if (take) begin
					d_next.cnt = 4'h0;
					d_next.fail = 1'b0;
					d_next.rdata = 32'h0;
					d_next.node = link.req_dest[15:0] == DEST_NODE;
					d_next.for_us = (link.req_dest[15:0] == DEST_TILE
						&& link.req_dest[31:16] == TILE_ID)
						|| (link.req_dest[15:0] == DEST_NODE
						&& link.req_dest[31:16] == NODE_ID);
					d_next.write = link.req_tok.val == TOK_WRITE;
					if (link.req_tok.ctrl && (link.req_tok.val == TOK_WRITE
						|| link.req_tok.val == TOK_READ)) begin
						d_next.st = S_BODY;
					end else if (!(link.req_tok.ctrl && link.req_tok.val == TOK_END)) begin
						d_next.st = S_DRAIN;
					end
				end
			end
			S_BODY: begin
				if (take) begin
					if (!link.req_tok.ctrl && d_reg.cnt < body) begin
						d_next.cnt = d_reg.cnt + 4'h1;
						if (d_reg.cnt <= RID_LAST) begin
							d_next.rid = {d_reg.rid[15:0], link.req_tok.val};
						end else if (d_reg.cnt <= REG_LAST) begin
							d_next.regnum = {d_reg.regnum[7:0], link.req_tok.val};
						end else begin
							d_next.wdata = {d_reg.wdata[23:0], link.req_tok.val};
						end
					end else if (link.req_tok.ctrl && link.req_tok.val == TOK_END) begin
						d_next.fail = d_reg.cnt != body;
						d_next.st = S_EXEC;
					end else begin
						d_next.fail = 1'b1;
						d_next.st = S_DRAIN;
					end
				end
			end
			S_DRAIN: begin
				// a broken message is swallowed up to its closing token
				if (take && link.req_tok.ctrl && link.req_tok.val == TOK_END) begin
					d_next.fail = 1'b1;
					d_next.st = S_EXEC;
				end
			end
			S_EXEC: begin
				// a message meant for another tile or node must leave our banks alone
				if (!d_reg.fail && d_reg.for_us) begin
					if (!reg_ok(d_reg.regnum, d_reg.node ? NODE_REGS : TILE_REGS)) begin
						d_next.fail = 1'b1;
					end else if (d_reg.write && d_reg.node) begin
						d_next.node_bank[d_reg.regnum] = d_reg.wdata;
					end else if (d_reg.write) begin
						d_next.tile[d_reg.regnum] = d_reg.wdata;
					end else if (d_reg.node) begin
						d_next.rdata = d_reg.node_bank[d_reg.regnum];
					end else begin
						d_next.rdata = d_reg.tile[d_reg.regnum];
					end
				end
				d_next.idx = 3'h0;
				d_next.len = (!d_reg.write && !d_next.fail) ? 3'h6 : 3'h2;
				// without a full return identifier there is nobody to answer
				if (!d_reg.for_us || d_reg.cnt <= RID_LAST
					|| (d_reg.write && d_reg.rid[7:0] == NOREPLY_LOW)) begin
					d_next.st = S_IDLE;
				end else begin
					d_next.st = S_REPLY;
				end
			end
			S_REPLY: begin
				if (!d_reg.rsp_valid || link.rsp_ready) begin
					if (d_reg.idx < d_reg.len) begin
						d_next.rsp_valid = 1'b1;
						d_next.rsp_tok = reply_tok(d_reg, d_reg.idx);
						d_next.idx = d_reg.idx + 3'h1;
					end else begin
						d_next.rsp_valid = 1'b0;
						d_next.st = S_IDLE;
					end
				end
			end
			default: begin
				d_next.st = S_IDLE;
			end
		endcase
		d_next.req_ready = d_next.st == S_IDLE || d_next.st == S_BODY || d_next.st == S_DRAIN;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			d_reg <= '0;
			d_reg.st <= S_IDLE;
			d_reg.req_ready <= 1'b1;
			d_reg.tile <= {TILE_REGS{CFG_RESET}};
			d_reg.node_bank <= {NODE_REGS{CFG_RESET}};
			d_reg.ps <= {PS_REGS{CFG_RESET}};
		end else begin
			d_reg <= d_next;
		end
	end

	assign link.req_ready = d_reg.req_ready;
	assign link.rsp_valid = d_reg.rsp_valid;
	assign link.rsp_tok = d_reg.rsp_tok;
	assign link.rsp_dest = d_reg.rid;
	assign link.ps_ack = d_reg.ps_ack;
	assign link.ps_ok = d_reg.ps_ok;
	assign link.ps_rdata = d_reg.ps_rdata;
	assign o_tile_cfg = d_reg.tile;
	assign o_node_cfg = d_reg.node_bank;
	assign o_ps_cfg = d_reg.ps;

endmodule : cfg_device_end
`default_nettype wire

/* File: src/cfg_msg_if.sv */
// Purpose: link between a requester and the configuration message port
// Assumes: both ends run on i_mclk; tokens move on valid and ready both high
// Notes: the processor-status group is a local request with a one-cycle answer
`timescale 1ns/10ps
`default_nettype none
interface cfg_msg_if (
	input wire logic i_mclk
);
	import cfg_msg_pkg::*;

	// request stream
	logic req_valid;
	logic req_ready;
	tok_type req_tok;
	logic [31:0] req_dest;
	// reply stream
	logic rsp_valid;
	logic rsp_ready;
	tok_type rsp_tok;
	logic [23:0] rsp_dest;
	// processor-status access
	logic ps_req;
	logic ps_wr;
	logic [15:0] ps_rid;
	logic [31:0] ps_wdata;
	logic ps_ack;
	logic ps_ok;
	logic [31:0] ps_rdata;

	modport device (
		input req_valid, req_tok, req_dest, rsp_ready, ps_req, ps_wr, ps_rid, ps_wdata,
		output req_ready, rsp_valid, rsp_tok, rsp_dest, ps_ack, ps_ok, ps_rdata
	);
	modport requester (
		output req_valid, req_tok, req_dest, rsp_ready, ps_req, ps_wr, ps_rid, ps_wdata,
		input req_ready, rsp_valid, rsp_tok, rsp_dest, ps_ack, ps_ok, ps_rdata
	);
endinterface : cfg_msg_if
`default_nettype wire

/* File: src/cfg_msg_pkg.sv */
// Purpose: shared tokens, destinations and helpers for the configuration message port
// Assumes: one link token is a control flag plus one byte
// Notes: multi-byte fields travel most significant byte first
package cfg_msg_pkg;

	typedef struct packed {
		logic ctrl;
		logic [7:0] val;
	} tok_type;

	// control token values
	localparam logic [7:0] TOK_END = 8'h01;
	localparam logic [7:0] TOK_ACK = 8'h03;
	localparam logic [7:0] TOK_NACK = 8'h04;
	localparam logic [7:0] TOK_WRITE = 8'hc0;
	localparam logic [7:0] TOK_READ = 8'hc1;

	// low half of the destination selects the bank
	localparam logic [15:0] DEST_TILE = 16'hc20c;
	localparam logic [15:0] DEST_NODE = 16'hc30c;

	// processor-status resource identifier
	localparam logic [7:0] PS_TYPE = 8'h0c;
	localparam int PS_SHIFT = 8;

	// return identifier low byte that asks for no reply
	localparam logic [7:0] NOREPLY_LOW = 8'hff;

	// body byte counts after the opening token, and the index of the last body byte of each field
	localparam logic [3:0] RD_BODY = 4'h5;
	localparam logic [3:0] WR_BODY = 4'h9;
	localparam logic [3:0] RID_LAST = 4'h2;
	localparam logic [3:0] REG_LAST = 4'h4;

	localparam logic [31:0] CFG_RESET = 32'h0;

	// byte i of a word, counted from the most significant end
	function automatic logic [7:0] byte_msb(input logic [31:0] w, input logic [1:0] i);
		return w[8 * (3 - i) +: 8];
	endfunction : byte_msb

endpackage : cfg_msg_pkg

/* File: src/cfg_requester_end.sv */
// Purpose: requester end that frames read and write messages and parses replies
// Assumes: one request at a time; i_go is taken only while o_busy is low
// Notes: a write whose return identifier ends in ff completes without a reply
`timescale 1ns/10ps
`default_nettype none
module cfg_requester_end (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// link
	cfg_msg_if.requester link,
	// message request
	input wire logic i_go,
	input wire logic i_write,
	input wire logic i_node,
	input wire logic [15:0] i_dest_id,
	input wire logic [23:0] i_ret_id,
	input wire logic [15:0] i_regnum,
	input wire logic [31:0] i_wdata,
	// message answer
	output logic o_busy,
	output logic o_done,
	output logic o_ok,
	output logic [31:0] o_rdata,
	// processor-status request
	input wire logic i_ps_go,
	input wire logic i_ps_write,
	input wire logic [7:0] i_ps_reg,
	input wire logic [31:0] i_ps_wdata,
	// processor-status answer
	output logic o_ps_done,
	output logic o_ps_ok,
	output logic [31:0] o_ps_rdata
);
	import cfg_msg_pkg::*;

	typedef enum logic [2:0] {R_IDLE = 3'b001, R_SEND = 3'b010, R_WAIT = 3'b100} rstate_type;

	typedef struct packed {
		rstate_type st;
		logic write;
		logic [23:0] rid;
		logic [15:0] regnum;
		logic [31:0] wdata;
		logic [3:0] idx;
		logic req_valid;
		tok_type req_tok;
		logic [31:0] dest;
		logic rsp_ready;
		logic busy;
		logic done;
		logic ok;
		logic [31:0] rdata;
		logic ps_req;
		logic ps_wr;
		logic [15:0] ps_rid;
		logic [31:0] ps_wdata;
		logic ps_done;
		logic ps_ok;
		logic [31:0] ps_rdata;
	} rq_type;

	rq_type q_reg, q_next;

	// token idx of the outgoing message
	function automatic tok_type msg_tok(input rq_type q, input logic [3:0] i);
		tok_type t;
		t = '{ctrl: 1'b0, val: 8'h00};
		if (i == 4'h0) begin
			t = '{ctrl: 1'b1, val: q.write ? TOK_WRITE : TOK_READ};
		end else if (i <= 4'h3) begin
			t.val = byte_msb({8'h00, q.rid}, 2'(i));
		end else if (i <= 4'h5) begin
			t.val = byte_msb({16'h0000, q.regnum}, 2'(i - 4'h2));
		end else if (q.write && i <= 4'h9) begin
			t.val = byte_msb(q.wdata, 2'(i - 4'h6));
		end else begin
			t = '{ctrl: 1'b1, val: TOK_END};
		end
		return t;
	endfunction : msg_tok

	always_comb begin
		logic [3:0] last;
		last = q_reg.write ? 4'ha : 4'h6;
		q_next = q_reg;
		q_next.done = 1'b0;
		q_next.ps_req = 1'b0;
		q_next.ps_done = 1'b0;
		if (q_reg.ps_req == 1'b0 && i_ps_go) begin
			q_next.ps_req = 1'b1;
			q_next.ps_wr = i_ps_write;
			q_next.ps_rid = {i_ps_reg, PS_TYPE};
			q_next.ps_wdata = i_ps_wdata;
		end
		if (link.ps_ack) begin
			q_next.ps_done = 1'b1;
			q_next.ps_ok = link.ps_ok;
			q_next.ps_rdata = link.ps_rdata;
		end
		case (q_reg.st)
			R_IDLE: begin
				if (i_go) begin
					q_next.st = R_SEND;
					q_next.busy = 1'b1;
					q_next.write = i_write;
					q_next.rid = i_ret_id;
					q_next.regnum = i_regnum;
					q_next.wdata = i_wdata;
					q_next.dest = {i_dest_id, i_node ? DEST_NODE : DEST_TILE};
					q_next.idx = 4'h0;
					q_next.rdata = 32'h0;
				end
			end
			R_SEND: begin
				if (!q_reg.req_valid || link.req_ready) begin
					if (q_reg.idx <= last) begin
						q_next.req_valid = 1'b1;
						q_next.req_tok = msg_tok(q_reg, q_reg.idx);
						q_next.idx = q_reg.idx + 4'h1;
					end else begin
						q_next.req_valid = 1'b0;
						if (q_reg.write && q_reg.rid[7:0] == NOREPLY_LOW) begin
							q_next.st = R_IDLE;
							q_next.busy = 1'b0;
							q_next.done = 1'b1;
							q_next.ok = 1'b1;
						end else begin
							q_next.st = R_WAIT;
							q_next.rsp_ready = 1'b1;
						end
					end
				end
			end
			R_WAIT: begin
				if (link.rsp_valid) begin
					if (!link.rsp_tok.ctrl) begin
						q_next.rdata = {q_reg.rdata[23:0], link.rsp_tok.val};
					end else if (link.rsp_tok.val == TOK_ACK) begin
						q_next.ok = 1'b1;
					end else if (link.rsp_tok.val == TOK_NACK) begin
						q_next.ok = 1'b0;
					end else if (link.rsp_tok.val == TOK_END) begin
						q_next.st = R_IDLE;
						q_next.rsp_ready = 1'b0;
						q_next.busy = 1'b0;
						q_next.done = 1'b1;
					end
				end
			end
			default: begin
				q_next.st = R_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			q_reg <= '0;
			q_reg.st <= R_IDLE;
		end else begin
			q_reg <= q_next;
		end
	end

	assign link.req_valid = q_reg.req_valid;
	assign link.req_tok = q_reg.req_tok;
	assign link.req_dest = q_reg.dest;
	assign link.rsp_ready = q_reg.rsp_ready;
	assign link.ps_req = q_reg.ps_req;
	assign link.ps_wr = q_reg.ps_wr;
	assign link.ps_rid = q_reg.ps_rid;
	assign link.ps_wdata = q_reg.ps_wdata;
	assign o_busy = q_reg.busy;
	assign o_done = q_reg.done;
	assign o_ok = q_reg.ok;
	assign o_rdata = q_reg.rdata;
	assign o_ps_done = q_reg.ps_done;
	assign o_ps_ok = q_reg.ps_ok;
	assign o_ps_rdata = q_reg.ps_rdata;

endmodule : cfg_requester_end
`default_nettype wire

/* File: tb/cfg_msg_asserts.sv */
// Purpose: protocol checks on the configuration message link
// Assumes: one clock, reset synchronous and active low
// Notes: follows the return identifier of the message in flight
`timescale 1ns/10ps
`default_nettype none
module cfg_msg_asserts
	import cfg_msg_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// link
	input wire logic req_valid,
	input wire logic req_ready,
	input wire tok_type req_tok,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire tok_type rsp_tok,
	input wire logic [23:0] rsp_dest,
	input wire logic ps_req,
	input wire logic [15:0] ps_rid,
	input wire logic ps_ack,
	input wire logic ps_ok
);
	logic take;
	logic [1:0] id_cnt;
	logic [23:0] id_reg;
	logic wr_reg;
	assign take = req_valid && req_ready;
	// the closing token is a control token too, so only openings restart the capture
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			id_cnt <= 2'h0;
			id_reg <= 24'h0;
			wr_reg <= 1'b0;
		end else if (take && req_tok.ctrl && req_tok.val != TOK_END) begin
			id_cnt <= 2'h3;
			wr_reg <= req_tok.val == TOK_WRITE;
		end else if (take && id_cnt != 2'h0) begin
			id_cnt <= id_cnt - 2'h1;
			id_reg <= {id_reg[15:0], req_tok.val};
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	property p_rsp_id;
		rsp_valid |-> rsp_dest == id_reg;
	endproperty
	a_rsp_id: assert property (p_rsp_id) else $error("reply sent to wrong channel end");
	property p_no_reply;
		rsp_valid |-> !(wr_reg && id_reg[7:0] == NOREPLY_LOW);
	endproperty
	a_no_reply: assert property (p_no_reply) else $error("reply to a write asking none");
	property p_first;
		$rose(rsp_valid) |-> rsp_tok == {1'b1, TOK_ACK} || rsp_tok == {1'b1, TOK_NACK};
	endproperty
	a_first: assert property (p_first) else $error("reply opens with a bad token");
	property p_nack_end;
		rsp_valid && rsp_ready && rsp_tok == {1'b1, TOK_NACK} |=>
			rsp_valid && rsp_tok == {1'b1, TOK_END};
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("failure reply not closed");
	property p_wr_ack;
		rsp_valid && rsp_ready && wr_reg && rsp_tok == {1'b1, TOK_ACK} |=>
			rsp_valid && rsp_tok == {1'b1, TOK_END};
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write success not closed");
	property p_rd_data;
		rsp_valid && rsp_ready && !wr_reg && rsp_tok == {1'b1, TOK_ACK} |=>
			(rsp_valid && !rsp_tok.ctrl)[*4] ##1 rsp_tok == {1'b1, TOK_END};
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read reply not four bytes");
	property p_ps_ack;
		ps_req |=> ps_ack;
	endproperty
	a_ps_ack: assert property (p_ps_ack) else $error("status access unanswered");
	property p_ps_cause;
		ps_ack |-> $past(ps_req);
	endproperty
	a_ps_cause: assert property (p_ps_cause) else $error("status answer without request");
	property p_ps_type;
		ps_ack && ps_ok |-> $past(ps_rid[7:0]) == PS_TYPE;
	endproperty
	a_ps_type: assert property (p_ps_type) else $error("status ok for bad identifier");
endmodule : cfg_msg_asserts
`default_nettype wire

/* File: tb/config_register_message_port_test.sv */
// Purpose: both ends joined, driven through the requester user side
// Assumes: tile id 0012, node id 0034, tile and node banks of 8, status bank of 16
// Notes: the foreign destination runs last since the requester then waits forever
`timescale 1ns/10ps
`default_nettype none
module config_register_message_port_test;
	import cfg_msg_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic go = 1'b0, wr = 1'b0, node = 1'b0, busy, done, ok, hit;
	logic [15:0] dst = 16'h0, rn = 16'h0;
	logic [23:0] rid = 24'h0;
	logic [31:0] wd = 32'h0, rdata, rsp_word = 32'h0;
	logic ps_go = 1'b0, ps_w = 1'b0, ps_done, ps_ok;
	logic [7:0] ps_reg = 8'h0;
	logic [31:0] ps_wd = 32'h0, ps_rdata;
	logic [7:0][31:0] tile_cfg, node_cfg;
	logic [15:0][31:0] ps_cfg;
	int err_total = 0, checked = 0, cycles = 0, rsp_cnt = 0, c;
	always #20 i_mclk = ~i_mclk;
	cfg_msg_if link (.i_mclk(i_mclk));
	cfg_requester_end cfg_requester_end_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(link),
		.i_go(go), .i_write(wr), .i_node(node), .i_dest_id(dst), .i_ret_id(rid),
		.i_regnum(rn), .i_wdata(wd), .o_busy(busy), .o_done(done), .o_ok(ok), .o_rdata(rdata),
		.i_ps_go(ps_go), .i_ps_write(ps_w), .i_ps_reg(ps_reg), .i_ps_wdata(ps_wd),
		.o_ps_done(ps_done), .o_ps_ok(ps_ok), .o_ps_rdata(ps_rdata));
	cfg_device_end #(.TILE_ID(16'h0012), .NODE_ID(16'h0034)) cfg_device_end_i (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .link(link), .o_tile_cfg(tile_cfg),
		.o_node_cfg(node_cfg), .o_ps_cfg(ps_cfg));
	cfg_msg_asserts cfg_msg_asserts_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.req_valid(link.req_valid), .req_ready(link.req_ready), .req_tok(link.req_tok),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_tok(link.rsp_tok),
		.rsp_dest(link.rsp_dest), .ps_req(link.ps_req), .ps_rid(link.ps_rid),
		.ps_ack(link.ps_ack), .ps_ok(link.ps_ok));
	// reply bytes gathered straight off the wire, independent of the requester;
	// sampled mid-cycle so the handshake seen is the one the next rising edge takes
	always @(negedge i_mclk) begin
		if (link.rsp_valid && link.rsp_ready && link.rsp_tok.ctrl && link.rsp_tok.val != TOK_END)
			rsp_cnt++;
		if (link.rsp_valid && link.rsp_ready && !link.rsp_tok.ctrl)
			rsp_word = {rsp_word[23:0], link.rsp_tok.val};
	end
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic msg(input logic w, input logic n, input logic [15:0] d,
		input logic [23:0] r, input logic [15:0] g, input logic [31:0] v, input logic eh,
		input logic eo);
		@(posedge i_mclk);
		#2;
		{go, wr, node, dst, rid, rn, wd} = {1'b1, w, n, d, r, g, v};
		@(posedge i_mclk);
		#2;
		go = 1'b0;
		hit = 1'b0;
		for (int k = 0; k < 60 && !hit; k++) begin
			@(posedge i_mclk);
			#1;
			hit = done;
		end
		chk("done", {31'h0, eh}, {31'h0, hit});
		chk("busy", {31'h0, !eh}, {31'h0, busy});
		if (eh)
			chk("ok", {31'h0, eo}, {31'h0, ok});
	endtask : msg
	task automatic ps_op(input logic w, input logic [7:0] g, input logic [31:0] v,
		input logic eo);
		@(posedge i_mclk);
		#2;
		{ps_go, ps_w, ps_reg, ps_wd} = {1'b1, w, g, v};
		@(posedge i_mclk);
		#2;
		ps_go = 1'b0;
		hit = 1'b0;
		for (int k = 0; k < 8 && !hit; k++) begin
			@(posedge i_mclk);
			#1;
			hit = ps_done;
		end
		chk("ps done", 32'h1, {31'h0, hit});
		chk("ps ok", {31'h0, eo}, {31'h0, ps_ok});
	endtask : ps_op
	initial begin
		repeat (16) @(posedge i_mclk);
		#2;
		i_rstn = 1'b1;
		msg(1, 0, 16'h0012, 24'h0a0b0c, 16'h3, 32'h12345678, 1, 1);
		chk("tile3", 32'h12345678, tile_cfg[3]);
		msg(0, 0, 16'h0012, 24'h0a0b0d, 16'h3, 32'h0, 1, 1);
		chk("rdata", 32'h12345678, rdata);
		chk("wire", 32'h12345678, rsp_word);
		msg(1, 1, 16'h0034, 24'h000101, 16'h7, 32'h89abcdef, 1, 1);
		chk("node7", 32'h89abcdef, node_cfg[7]);
		chk("tile7", 32'h0, tile_cfg[7]);
		msg(0, 1, 16'h0034, 24'h000102, 16'h7, 32'h0, 1, 1);
		chk("rdata", 32'h89abcdef, rdata);
		msg(1, 0, 16'h0012, 24'h0a0b0c, 16'h8, 32'hffffffff, 1, 0);
		chk("tile3", 32'h12345678, tile_cfg[3]);
		msg(0, 1, 16'h0034, 24'h000103, 16'h0100, 32'h0, 1, 0);
		c = rsp_cnt;
		msg(1, 0, 16'h0012, 24'h0a0bff, 16'h1, 32'h5a5a5a5a, 1, 1);
		chk("replies", c, rsp_cnt);
		// with no reply the requester is done before the device has executed the write
		@(posedge i_mclk);
		#2;
		chk("tile1", 32'h5a5a5a5a, tile_cfg[1]);
		msg(0, 0, 16'h0012, 24'h0a0bff, 16'h1, 32'h0, 1, 1);
		chk("rdata", 32'h5a5a5a5a, rdata);
		ps_op(1, 8'h5, 32'hcafe0001, 1);
		chk("ps5", 32'hcafe0001, ps_cfg[5]);
		ps_op(0, 8'h5, 32'h0, 1);
		chk("ps rdata", 32'hcafe0001, ps_rdata);
		ps_op(0, 8'h10, 32'h0, 0);
		c = rsp_cnt;
		msg(1, 0, 16'h0013, 24'h0a0b0c, 16'h2, 32'h1, 0, 0);
		chk("tile2", 32'h0, tile_cfg[2]);
		chk("replies", c, rsp_cnt);
		conclude();
	end
endmodule : config_register_message_port_test
`default_nettype wire
